/* slow_osc_irq_defines.vh */
// Constants for the slow oscillator interrupt and event logic
`ifndef SLOW_OSC_IRQ_DEFINES_VH
`define SLOW_OSC_IRQ_DEFINES_VH
`define SRC_W 2
`define SRC_CRYSTAL 0
`define SRC_FAILURE 1
`define SRC_NONE 2'h0
`define EVENT_CONTROL_OFFSET 8'h00
`define EVENT_CONTROL_RESET 1'h0
`define FLAG_RESET 2'h0
`define ENABLE_RESET 2'h0
`define SYNC_DEPTH 3
`define SYNC_STAGE1 0
`define SYNC_STAGE2 1
`define SYNC_STAGE3 2
`define SYNC_RESET 3'h0
`define LEVEL_RESET 1'h0
`define RST_ASSERTED 1'h0
`define RST_RELEASED 1'h1
`define REQUEST_RESET 1'h0
`define EVENT_RESET 1'h0
`endif

/* slow_osc_irq_event_logic.v */
// Interrupt flags, enables and clock-failure event of the slow oscillator controller
`timescale 1ns/10ps
`include "slow_osc_irq_defines.vh"

// Operation
// - A low-to-high change of crystal-ready status is the crystal-ready interrupt condition.
// - A low-to-high change of clock-failure status is the clock-failure interrupt condition.
// - Both sources wake the system synchronously while the bus clock runs.
// - Each source has its own flag that hardware sets when the condition occurs.
// - Enables are set by writing one to enable-set and cleared by writing one to enable-clear.
// - The request is raised while a flag and its own enable are both set.
// - The request holds until the flag is cleared, the enable removed or reset.
// - All source requests share one interrupt output.
// - A clock-failure event is sent to the event system when clock-failure status sets.
// - The clock-failure event is suppressed while switch-back status is set.
// - Writing one to the event output enable enables the event, zero disables it.
// - The event output enable is bit 0 of event control at offset 0x00, reset zero.
module slow_osc_irq_event_logic (
  input wire clk_sys,
  input wire rst_n,
  input wire crystal_ready_status,
  input wire clock_failure_status,
  input wire clock_switch_back_status,
  input wire interrupt_enable_set_wr,
  input wire interrupt_enable_clear_wr,
  input wire interrupt_flag_clear_wr,
  input wire [`SRC_W-1:0] wr_data,
  input wire event_control_wr,
  input wire failure_event_output_enable_wdata,
  output reg [`SRC_W-1:0] interrupt_flag_register,
  output reg [`SRC_W-1:0] interrupt_enable_register,
  output reg failure_event_output_enable,
  output reg irq,
  output reg wake_request,
  output reg clock_failure_event
);

  reg rst_meta_q;
  reg rst_sync_q;
  reg [`SYNC_DEPTH-1:0] crystal_sync_q;
  reg [`SYNC_DEPTH-1:0] failure_sync_q;
  reg [`SYNC_DEPTH-1:0] switch_back_sync_q;
  reg crystal_level_q;
  reg crystal_level_d;
  reg failure_level_q;
  reg failure_level_d;
  reg switch_back_level_q;
  reg switch_back_level_d;
  reg crystal_rise_d;
  reg failure_rise_d;
  reg [`SRC_W-1:0] rise_d;
  reg [`SRC_W-1:0] flag_kept_d;
  reg [`SRC_W-1:0] flag_d;
  reg [`SRC_W-1:0] enable_set_d;
  reg [`SRC_W-1:0] enable_d;
  reg event_enable_d;
  reg irq_d;
  reg wake_d;
  reg event_d;

  // Filtered level: moves only when stages two and three agree
  function level_next;
    input [`SYNC_DEPTH-1:0] stages;
    input current;
    begin
      if (stages[`SYNC_STAGE2] == stages[`SYNC_STAGE3]) begin
        level_next = stages[`SYNC_STAGE3];
      end else begin
        level_next = current;
      end
    end
  endfunction

  // Low-to-high change of a filtered level
  function rise_of;
    input next_level;
    input current;
    begin
      rise_of = next_level & ~current;
    end
  endfunction

  // Bits written as one are set
  function [`SRC_W-1:0] set_bits;
    input [`SRC_W-1:0] value;
    input strobe;
    input [`SRC_W-1:0] mask;
    begin
      if (strobe) begin
        set_bits = value | mask;
      end else begin
        set_bits = value;
      end
    end
  endfunction

  // Bits written as one are cleared
  function [`SRC_W-1:0] clear_bits;
    input [`SRC_W-1:0] value;
    input strobe;
    input [`SRC_W-1:0] mask;
    begin
      if (strobe) begin
        clear_bits = value & ~mask;
      end else begin
        clear_bits = value;
      end
    end
  endfunction

  // Any source both flagged and enabled
  function request_of;
    input [`SRC_W-1:0] flags;
    input [`SRC_W-1:0] enables;
    begin
      request_of = |(flags & enables);
    end
  endfunction

  // Failure event, held back while switch-back is reported
  function event_of;
    input rise_in;
    input enable_in;
    input hold_in;
    begin
      if (hold_in) begin
        event_of = `EVENT_RESET;
      end else begin
        event_of = rise_in & enable_in;
      end
    end
  endfunction

  // Reset release
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= `RST_ASSERTED;
      rst_sync_q <= `RST_ASSERTED;
    end else begin
      rst_meta_q <= `RST_RELEASED;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Crystal-ready synchroniser
  always @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      crystal_sync_q <= `SYNC_RESET;
    end else begin
      crystal_sync_q <= {crystal_sync_q[`SYNC_STAGE2:`SYNC_STAGE1], crystal_ready_status};
    end
  end

  // Clock-failure synchroniser
  always @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      failure_sync_q <= `SYNC_RESET;
    end else begin
      failure_sync_q <= {failure_sync_q[`SYNC_STAGE2:`SYNC_STAGE1], clock_failure_status};
    end
  end

  // Switch-back synchroniser
  always @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      switch_back_sync_q <= `SYNC_RESET;
    end else begin
      switch_back_sync_q <= {switch_back_sync_q[`SYNC_STAGE2:`SYNC_STAGE1],
        clock_switch_back_status};
    end
  end

  // Crystal-ready filtered level
  always @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      crystal_level_q <= `LEVEL_RESET;
    end else begin
      crystal_level_q <= crystal_level_d;
    end
  end

  // Clock-failure filtered level
  always @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      failure_level_q <= `LEVEL_RESET;
    end else begin
      failure_level_q <= failure_level_d;
    end
  end

  // Switch-back filtered level
  always @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      switch_back_level_q <= `LEVEL_RESET;
    end else begin
      switch_back_level_q <= switch_back_level_d;
    end
  end

  // Filtered levels
  always @* begin
    crystal_level_d = level_next(crystal_sync_q, crystal_level_q);
    failure_level_d = level_next(failure_sync_q, failure_level_q);
    switch_back_level_d = level_next(switch_back_sync_q, switch_back_level_q);
  end

  // Rising changes per source
  always @* begin
    crystal_rise_d = rise_of(crystal_level_d, crystal_level_q);
    failure_rise_d = rise_of(failure_level_d, failure_level_q);
    rise_d = `SRC_NONE;
    rise_d[`SRC_CRYSTAL] = crystal_rise_d;
    rise_d[`SRC_FAILURE] = failure_rise_d;
  end

  // Flags: clear write first, then new conditions, so a set wins
  always @* begin
    flag_kept_d = clear_bits(interrupt_flag_register, interrupt_flag_clear_wr, wr_data);
    flag_d = set_bits(flag_kept_d, |rise_d, rise_d);
  end

  // Flag register
  always @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      interrupt_flag_register <= `FLAG_RESET;
    end else begin
      interrupt_flag_register <= flag_d;
    end
  end

  // Enables: set first, then clear, so a clear wins
  always @* begin
    enable_set_d = set_bits(interrupt_enable_register, interrupt_enable_set_wr, wr_data);
    enable_d = clear_bits(enable_set_d, interrupt_enable_clear_wr, wr_data);
  end

  // Enable register, read back for both set and clear
  always @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      interrupt_enable_register <= `ENABLE_RESET;
    end else begin
      interrupt_enable_register <= enable_d;
    end
  end

  // Event output enable write
  always @* begin
    event_enable_d = failure_event_output_enable;
    if (event_control_wr) begin
      event_enable_d = failure_event_output_enable_wdata;
    end
  end

  // Event output enable register
  always @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      failure_event_output_enable <= `EVENT_CONTROL_RESET;
    end else begin
      failure_event_output_enable <= event_enable_d;
    end
  end

  // Shared request from any flagged and enabled source
  always @* begin
    irq_d = request_of(flag_d, enable_d);
    wake_d = request_of(flag_d, enable_d);
  end

  // Interrupt request line
  always @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      irq <= `REQUEST_RESET;
    end else begin
      irq <= irq_d;
    end
  end

  // Wake-up request line
  always @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      wake_request <= `REQUEST_RESET;
    end else begin
      wake_request <= wake_d;
    end
  end

  // Failure event from the rising change
  always @* begin
    event_d = event_of(failure_rise_d, failure_event_output_enable, switch_back_level_q);
  end

  // One-cycle failure event
  always @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      clock_failure_event <= `EVENT_RESET;
    end else begin
      clock_failure_event <= event_d;
    end
  end

endmodule // slow_osc_irq_event_logic

/* slow_osc_irq_event_logic_props.sv */
// Port checker of the slow oscillator interrupt logic
`timescale 1ns/10ps
module slow_osc_irq_props (
  input wire clk_sys,
  input wire rst_n,
  input wire crystal_ready_status,
  input wire clock_failure_status,
  input wire clock_switch_back_status,
  input wire failure_event_output_enable,
  input wire irq,
  input wire wake_request,
  input wire clock_failure_event,
  input wire [1:0] interrupt_flag_register,
  input wire [1:0] interrupt_enable_register
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire ev = clock_failure_event;
  wire [1:0] f = interrupt_flag_register, e = interrupt_enable_register;
  sequence rise(s); $rose(s) ##1 s[*2]; endsequence
  irq_or_a: assert property (irq == |(f & e) && wake_request == irq)
    else $error("irq");
  xr_set_a: assert property (rise(crystal_ready_status) |=> ##1 f[0]) else $error("f0");
  cf_set_a: assert property (rise(clock_failure_status) |=> ##1 f[1]) else $error("f1");
  ev_pulse_a: assert property (ev |=> !ev) else $error("pulse");
  ev_flag_a: assert property (ev |-> f[1]) else $error("flag");
  ev_gate_a: assert property (ev |-> $past(failure_event_output_enable)) else $error("en");
  sw_block_a: assert property (clock_switch_back_status[*6] |-> !ev) else $error("sw");
  ev_rise_a: assert property (ev |-> $past(clock_failure_status, 4)
    && !$past(clock_failure_status, 5)) else $error("rise");
endmodule // slow_osc_irq_props
bind slow_osc_irq_event_logic slow_osc_irq_props slow_osc_irq_props_i (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .crystal_ready_status(crystal_ready_status),
  .clock_failure_status(clock_failure_status),
  .clock_switch_back_status(clock_switch_back_status),
  .failure_event_output_enable(failure_event_output_enable),
  .irq(irq),
  .wake_request(wake_request),
  .clock_failure_event(clock_failure_event),
  .interrupt_flag_register(interrupt_flag_register),
  .interrupt_enable_register(interrupt_enable_register)
);

/* irq_event_sink.sv */
// Event router and interrupt controller stand-in
`timescale 1ns/10ps
module irq_event_sink (
  input wire clk_sys,
  input wire ge,
  input wire irq,
  input wire ev,
  input wire [1:0] fl,
  output logic [7:0] n = 8'h00,
  output logic [1:0] c = 2'h0
);
  always @(posedge clk_sys) begin
    n <= n + {7'h00, ev};
    if (irq && ge) c <= fl;
  end
endmodule // irq_event_sink

/* tb_slow_osc_irq_event_logic.sv */
// Bench of the slow oscillator interrupt logic
`timescale 1ns/10ps
module tb_slow_osc_irq_event_logic;
  logic clk_sys = 0, rst_n = 0, ge = 1, fe, irq, wk, ev;
  logic [3:0] st = 4'h0; logic [2:0] p = 3'h0; logic [1:0] d = 2'h0, fl, en, c, x = 2'h0;
  logic [7:0] n; logic [31:0] r = 32'h4D20; int n_mismatch = 0, checked = 0, cyc = 0;
  slow_osc_irq_event_logic slow_osc_irq_event_logic_i(.clk_sys, .rst_n,
    .crystal_ready_status(p[0]), .clock_failure_status(p[1]), .clock_switch_back_status(p[2]),
    .interrupt_enable_set_wr(st[0]), .interrupt_enable_clear_wr(st[1]),
    .interrupt_flag_clear_wr(st[2]), .event_control_wr(st[3]), .wr_data(d),
    .failure_event_output_enable_wdata(d[0]), .interrupt_flag_register(fl),
    .interrupt_enable_register(en), .failure_event_output_enable(fe), .irq,
    .wake_request(wk), .clock_failure_event(ev));
  irq_event_sink irq_event_sink_i(.clk_sys, .ge, .irq, .ev, .fl, .n, .c);
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc == 2000) begin
    n_mismatch++;
    $display("MISMATCH %0t timeout", $time);
    print_verdict;
  end
  function automatic [31:0] lfsr(input [31:0] v); return {v[30:0], v[31]^v[21]^v[1]^v[0]}; endfunction
  function automatic [1:0] en_nx(input [1:0] e, v, input s, k); return (e|(s?v:2'h0))&~(k?v:2'h0); endfunction
  task chk(input logic [7:0] g, e);
    checked++;
    if (g !== e) begin n_mismatch++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end
  endtask
  task wr(input [3:0] s, input [1:0] v);
    @(posedge clk_sys) {st, d} <= {s, v};
    @(posedge clk_sys) st <= 4'h0;
    #1;
  endtask
  task pin(input [2:0] v);
    @(posedge clk_sys) p <= v;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk_sys);
    #1 chk({fl, en, fe, irq, wk, ev}, 8'h00);
    wr(4'h8, 2'h1); chk(fe, 8'h01);
    repeat (30) begin
      r = lfsr(r);
      x = en_nx(x, r[1:0], r[2], r[3]);
      wr({2'h0, r[3:2]}, r[1:0]); chk(en, x);
    end
    $display("random test done");
    wr(4'h1, 2'h3); pin(3'h1); chk({fl, irq, wk}, 8'h07);
    pin(3'h3); chk({n[3:0], fl, c}, 8'h1F);
    wr(4'h4, 2'h1); chk({fl, irq, wk}, 8'h0B);
    wr(4'h2, 2'h2); chk({en, irq, wk}, 8'h04);
    pin(3'h5); pin(3'h7); chk(n, 8'h01);
    wr(4'h8, 2'h0); chk(fe, 8'h00);
    pin(3'h1); pin(3'h3); chk(n, 8'h01);
    $display("directed test done");
    wr(4'h1, 2'h3); chk({fl, en, irq, wk}, 8'h2F);
    @(posedge clk_sys) rst_n <= 1'h0;
    #1 chk({fl, en, fe, irq, wk, ev}, 8'h00);
    @(posedge clk_sys) rst_n <= 1'h1;
    repeat (8) @(posedge clk_sys);
    #1 chk({fl, en, fe, irq, wk, ev}, 8'hC0);
    $display("reset test done");
    print_verdict;
  end
endmodule // tb_slow_osc_irq_event_logic
